// [verilog/rtc_irq_top.sv]
// Alarm and time-update interrupt block with AHB-Lite register slave
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ns
module rtc_irq_top
    import rtc_irq_pkg::*;
#(
    parameter int SEC_COUNT = SEC_CYCLES,
    parameter int RELEASE_COUNT = REL_MIN_CYCLES
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Open-drain interrupt pin
    input wire logic irq_pin_n_in,
    output logic irq_pin_n_out,
    output logic irq_pin_n_oe,
    // Level interrupt to the system
    output logic irq
);

    // ----------------------------------------------------------------
    // Bus front end
    // ----------------------------------------------------------------
    logic wr_q;
    logic wr_d;
    logic [5:0] widx_q;
    logic [5:0] widx_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic acc;
    logic mapped;
    logic [5:0] aidx;
    logic [7:0] wb;

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    rtc_time_t tm_q;
    rtc_time_t tm_d;
    alarm_set_t al_q;
    alarm_set_t al_d;
    logic [7:0] ext_q;
    logic [7:0] ext_d;
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [IRQ_W-1:0] mask_q;
    logic [IRQ_W-1:0] mask_d;
    logic [CNT_W-1:0] pre_q;
    logic [CNT_W-1:0] pre_d;

    // ----------------------------------------------------------------
    // Event and pin state
    // ----------------------------------------------------------------
    logic sec_tick;
    logic min_tick;
    logic chk_q;
    logic chk_d;
    logic match;
    logic day_ok;
    logic alarm_evt;
    logic upd_evt;
    logic flag_wr;
    logic af_clr;
    logic uf_clr;
    logic [1:0] flags;
    logic [IRQ_W-1:0] istat;
    logic [IRQ_W-1:0] ist_clr;
    logic upd_low_q;
    logic upd_low_d;
    logic [CNT_W-1:0] rel_q;
    logic [CNT_W-1:0] rel_d;
    logic drive_q;
    logic drive_d;
    logic irq_q;
    logic irq_d;
    logic pin_s1_q;
    logic pin_s2_q;
    logic wr_tm;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    assign acc = hsel && hready && (htrans == HTRANS_NONSEQ)
                 && (hsize == HSIZE_WORD);
    assign aidx = haddr[IDX_MSB:IDX_LSB];
    assign wb = hwdata[7:0];

    always_comb begin
        mapped = 1'b1;
        rdata_d = '0;
        case (aidx)
            IDX_SEC: rdata_d[7:0] = tm_q.sec;
            IDX_MIN: rdata_d[7:0] = tm_q.min;
            IDX_HOUR: rdata_d[7:0] = tm_q.hour;
            IDX_WDAY: rdata_d[2:0] = tm_q.wday;
            IDX_DATE: rdata_d[7:0] = tm_q.date;
            IDX_AL_MIN: rdata_d[7:0] = al_q.min;
            IDX_AL_HOUR: rdata_d[7:0] = al_q.hour;
            IDX_AL_DAY: rdata_d[7:0] = al_q.day;
            IDX_EXT: rdata_d[7:0] = ext_q;
            IDX_FLAG: begin
                rdata_d[FLAG_UF] = flags[1];
                rdata_d[FLAG_AF] = flags[0];
            end
            IDX_CTRL: rdata_d[7:0] = ctrl_q;
            IDX_ISTAT: begin
                rdata_d[IRQ_W-1:0] = istat;
                rdata_d[IST_PIN] = ~pin_s2_q;
            end
            IDX_IMASK: rdata_d[IRQ_W-1:0] = mask_q;
            default: mapped = 1'b0;
        endcase
        if ((haddr[31:IDX_MSB+1] != '0) || !mapped) begin
            mapped = 1'b0;
            rdata_d = '0;
        end
        wr_d = acc && hwrite && mapped;
        widx_d = aidx;
        if (!(acc && !hwrite)) begin
            rdata_d = rdata_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            widx_q <= '0;
            rdata_q <= '0;
        end else begin
            wr_q <= wr_d;
            widx_q <= widx_d;
            rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------------------------------
    // Time base and configuration registers
    // ----------------------------------------------------------------
    assign wr_tm = wr_q && (widx_q >= IDX_SEC) && (widx_q <= IDX_DATE);

    always_comb begin
        sec_tick = !ctrl_q[CTRL_STOP]
                   && (pre_q == CNT_W'(SEC_COUNT - 1));
        min_tick = sec_tick && (tm_q.sec >= SEC_MAX);
        pre_d = pre_q;
        if (wr_tm) begin
            pre_d = '0;
        end else if (sec_tick) begin
            pre_d = '0;
        end else if (!ctrl_q[CTRL_STOP]) begin
            pre_d = pre_q + CNT_W'(1);
        end
        tm_d = tm_q;
        if (sec_tick) begin
            tm_d.sec = bcd_next(tm_q.sec, SEC_MAX, REG_RST);
            if (min_tick) begin
                tm_d.min = bcd_next(tm_q.min, MIN_MAX, REG_RST);
                if (tm_q.min >= MIN_MAX) begin
                    tm_d.hour = bcd_next(tm_q.hour, HOUR_MAX, REG_RST);
                    if (tm_q.hour >= HOUR_MAX) begin
                        tm_d.date = bcd_next(tm_q.date, DATE_MAX, DATE_RST);
                        tm_d.wday = (tm_q.wday >= WDAY_MAX) ? '0
                                    : tm_q.wday + 3'h1;
                    end
                end
            end
        end
        al_d = al_q;
        ext_d = ext_q;
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        if (wr_q) begin
            case (widx_q)
                IDX_SEC: tm_d.sec = wb;
                IDX_MIN: tm_d.min = wb;
                IDX_HOUR: tm_d.hour = wb;
                IDX_WDAY: tm_d.wday = wb[2:0];
                IDX_DATE: tm_d.date = wb;
                IDX_AL_MIN: al_d.min = wb;
                IDX_AL_HOUR: al_d.hour = wb;
                IDX_AL_DAY: al_d.day = wb;
                IDX_EXT: ext_d = wb;
                IDX_CTRL: ctrl_d = wb;
                IDX_IMASK: mask_d = wb[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_q <= '0;
            tm_q <= '{REG_RST, REG_RST, REG_RST, 3'h0, DATE_RST};
            al_q <= '{REG_RST, REG_RST, REG_RST};
            ext_q <= REG_RST;
            ctrl_q <= REG_RST;
            mask_q <= '0;
        end else begin
            pre_q <= pre_d;
            tm_q <= tm_d;
            al_q <= al_d;
            ext_q <= ext_d;
            ctrl_q <= ctrl_d;
            mask_q <= mask_d;
        end
    end

    // ----------------------------------------------------------------
    // Alarm compare
    // ----------------------------------------------------------------
    always_comb begin
        if (ext_q[EXT_WEEK_DAY_SELECT]) begin
            day_ok = (al_q.day[5:0] == tm_q.date[5:0]);
        end else begin
            day_ok = al_q.day[tm_q.wday];
        end
        match = (al_q.min[AL_IGNORE] || (al_q.min[6:0] == tm_q.min[6:0]))
                && (al_q.hour[AL_IGNORE]
                    || (al_q.hour[5:0] == tm_q.hour[5:0]))
                && (al_q.day[AL_IGNORE] || day_ok);
        chk_d = min_tick;
    end

    // Compared one cycle after the minute rolls, against the new time
    assign alarm_evt = chk_q && match;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chk_q <= 1'b0;
        end else begin
            chk_q <= chk_d;
        end
    end

    // ----------------------------------------------------------------
    // Update event and event flags
    // ----------------------------------------------------------------
    assign upd_evt = !ctrl_q[CTRL_STOP]
                     && (ext_q[EXT_UPDATE_PERIOD_SELECT] ? min_tick : sec_tick);
    assign flag_wr = wr_q && (widx_q == IDX_FLAG);
    assign af_clr = flag_wr && !wb[FLAG_AF];
    assign uf_clr = flag_wr && !wb[FLAG_UF];

    sticky_flag #(
        .W(2)
    ) u_event_flags (
        .hclk(hclk),
        .hresetn(hresetn),
        .set({upd_evt, alarm_evt}),
        .clr({uf_clr, af_clr}),
        .q(flags)
    );

    // ----------------------------------------------------------------
    // Update low-drive window
    // ----------------------------------------------------------------
    always_comb begin
        upd_low_d = upd_low_q;
        rel_d = rel_q;
        if (upd_evt) begin
            upd_low_d = 1'b1;
            rel_d = '0;
        end else if (upd_low_q) begin
            if (uf_clr || (rel_q == CNT_W'(RELEASE_COUNT - 1))) begin
                upd_low_d = 1'b0;
            end else begin
                rel_d = rel_q + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            upd_low_q <= 1'b0;
            rel_q <= '0;
        end else begin
            upd_low_q <= upd_low_d;
            rel_q <= rel_d;
        end
    end

    // ----------------------------------------------------------------
    // Pin drive and system interrupt
    // ----------------------------------------------------------------
    always_comb begin
        drive_d = (flags[0] && ctrl_q[CTRL_AIE])
                  || (upd_low_q && ctrl_q[CTRL_UIE]);
        irq_d = |(istat & mask_q);
    end

    assign ist_clr = (wr_q && (widx_q == IDX_ISTAT)) ? wb[IRQ_W-1:0] : '0;

    sticky_flag #(
        .W(IRQ_W)
    ) u_irq_status (
        .hclk(hclk),
        .hresetn(hresetn),
        .set({upd_evt, alarm_evt}),
        .clr(ist_clr),
        .q(istat)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive_q <= 1'b0;
            irq_q <= 1'b0;
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
        end else begin
            drive_q <= drive_d;
            irq_q <= irq_d;
            pin_s1_q <= irq_pin_n_in;
            pin_s2_q <= pin_s1_q;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    logic zero_q;
    logic one_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            zero_q <= 1'b0;
            one_q <= 1'b1;
        end else begin
            zero_q <= 1'b0;
            one_q <= 1'b1;
        end
    end

    assign hrdata = rdata_q;
    assign hreadyout = one_q;
    assign hresp = zero_q;
    assign irq_pin_n_out = zero_q;
    assign irq_pin_n_oe = drive_q;
    assign irq = irq_q;

endmodule

// [verilog/rtc_irq_pkg.sv]
// Constants, types and helpers for the alarm and time-update interrupt block
package rtc_irq_pkg;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 7;
    localparam logic [5:0] IDX_SEC = 6'h10;
    localparam logic [5:0] IDX_MIN = 6'h11;
    localparam logic [5:0] IDX_HOUR = 6'h12;
    localparam logic [5:0] IDX_WDAY = 6'h13;
    localparam logic [5:0] IDX_DATE = 6'h14;
    localparam logic [5:0] IDX_AL_MIN = 6'h18;
    localparam logic [5:0] IDX_AL_HOUR = 6'h19;
    localparam logic [5:0] IDX_AL_DAY = 6'h1a;
    localparam logic [5:0] IDX_EXT = 6'h1c;
    localparam logic [5:0] IDX_FLAG = 6'h1d;
    localparam logic [5:0] IDX_CTRL = 6'h1e;
    localparam logic [5:0] IDX_ISTAT = 6'h20;
    localparam logic [5:0] IDX_IMASK = 6'h21;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int EXT_UPDATE_PERIOD_SELECT = 5;
    localparam int EXT_WEEK_DAY_SELECT = 3;
    localparam int FLAG_UF = 5;
    localparam int FLAG_AF = 3;
    localparam int CTRL_STOP = 6;
    localparam int CTRL_UIE = 5;
    localparam int CTRL_AIE = 3;
    localparam int AL_IGNORE = 7;
    localparam int IST_ALARM = 0;
    localparam int IST_UPDATE = 1;
    localparam int IST_PIN = 2;
    localparam int IRQ_W = 2;

    // ----------------------------------------------------------------
    // Reset values and counter limits
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] DATE_RST = 8'h01;
    localparam logic [7:0] SEC_MAX = 8'h59;
    localparam logic [7:0] MIN_MAX = 8'h59;
    localparam logic [7:0] HOUR_MAX = 8'h23;
    localparam logic [7:0] DATE_MAX = 8'h31;
    localparam logic [2:0] WDAY_MAX = 3'h6;
    localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int SEC_NS = 1000000000;
    localparam int REL_MIN_NS = 7570000;
    localparam int REL_MAX_NS = 15630000;
    localparam int SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;
    localparam int REL_MIN_CYCLES =
        (REL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REL_MAX_CYCLES = REL_MAX_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 24;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [2:0] wday;
        logic [7:0] date;
    } rtc_time_t;

    typedef struct packed {
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] day;
    } alarm_set_t;

    // BCD increment with wrap to a given low value
    function automatic logic [7:0] bcd_next(input logic [7:0] v,
                                            input logic [7:0] top,
                                            input logic [7:0] low);
        logic [7:0] r;
        if (v >= top) begin
            r = low;
        end else if (v[3:0] == BCD_DIGIT_MAX) begin
            r = {v[7:4] + 4'h1, 4'h0};
        end else begin
            r = {v[7:4], v[3:0] + 4'h1};
        end
        return r;
    endfunction

endpackage

// [verilog/sticky_flag.sv]
// Sticky flag bits: set wins over clear
`timescale 1ns/1ns
module sticky_flag
    import rtc_irq_pkg::*;
#(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Set and clear
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    // State
    output logic [W-1:0] q
);

    logic [W-1:0] q_q;
    logic [W-1:0] q_d;

    always_comb begin
        q_d = set | (q_q & ~clr);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q_q <= '0;
        end else begin
            q_q <= q_d;
        end
    end

    assign q = q_q;

endmodule

// [testbench/rtc_irq_checker.sv]
// Port checker for the alarm and update interrupt block
`timescale 1ns/1ns
module rtc_irq_checker
    import rtc_irq_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Interrupt pin and level
    input wire logic irq_pin_n_in,
    input wire logic irq_pin_n_out,
    input wire logic irq_pin_n_oe,
    input wire logic irq
);
    // ------
    // Data phase tracking
    // ------
    logic take;
    logic wr_q;
    logic rd_q;
    logic hi_q;
    logic [5:0] idx_q;
    assign take = hsel && hready && htrans == HTRANS_NONSEQ;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            hi_q <= 1'b0;
            idx_q <= 6'h00;
        end else begin
            wr_q <= take && hwrite && hsize == HSIZE_WORD;
            rd_q <= take && !hwrite && hsize == HSIZE_WORD;
            hi_q <= haddr[31:8] != 24'h0;
            idx_q <= haddr[7:2];
        end
    end
    // ------
    // Assertions
    // ------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    a_ready_okay: assert property (hreadyout && !hresp)
        else $error("bus slave not ready or not okay");
    a_open_drain: assert property (irq_pin_n_oe |-> !irq_pin_n_out)
        else $error("interrupt pin driven high");
    a_rdata_upper: assert property (hrdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_unmapped_zero: assert property (rd_q && hi_q |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_narrow_ignored: assert property (
        !(take && !hwrite && hsize == HSIZE_WORD) |=> $stable(hrdata))
        else $error("read data changed without a word read");
    a_flag_release: assert property (
        wr_q && idx_q == IDX_FLAG && !hwdata[FLAG_UF] && !hwdata[FLAG_AF]
        |-> ##[1:4] !irq_pin_n_oe)
        else $error("flag clear did not release pin");
    a_enable_release: assert property (
        wr_q && idx_q == IDX_CTRL && !hwdata[CTRL_UIE] && !hwdata[CTRL_AIE]
        |-> ##[1:4] !irq_pin_n_oe)
        else $error("enable clear did not release pin");
    a_mask_quiet: assert property (
        wr_q && idx_q == IDX_IMASK && hwdata[1:0] == 2'h0 |-> ##[1:4] !irq)
        else $error("masked interrupt still high");
endmodule

bind rtc_irq_top rtc_irq_checker u_chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq_pin_n_in(irq_pin_n_in),
    .irq_pin_n_out(irq_pin_n_out), .irq_pin_n_oe(irq_pin_n_oe), .irq(irq));

// [testbench/irq_wire_host.sv]
// Host side of the shared open-drain interrupt wire
`timescale 1ns/1ns
module irq_wire_host (
    // Device drive
    input wire logic drv_oe,
    input wire logic drv_out,
    // Another source on the shared wire
    input wire logic other_low,
    // Resolved wire, pulled up
    output logic wire_n
);
    // Pull-up wins unless some source sinks the wire
    assign wire_n = ((drv_oe && !drv_out) || other_low) ? 1'b0 : 1'b1;
endmodule

// [testbench/rtc_alarm_update_irq_tb.sv]
// Self-checking bench for the alarm and update interrupt block
`timescale 1ns/1ns
module rtc_alarm_update_irq_tb;
    import rtc_irq_pkg::*;
    // ------
    // Signals and instances
    // ------
    localparam int SECN = 20;
    localparam int RELN = 8;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = HSIZE_WORD;
    logic [31:0] hwdata = 32'h0;
    logic other_low = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, pin_out, pin_oe, irq, wire_n;
    int bad_count = 0;
    int cmp_count = 0;
    int n, n1, n2;
    always #50 hclk = ~hclk;
    rtc_irq_top #(.SEC_COUNT(SECN), .RELEASE_COUNT(RELN)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .irq_pin_n_in(wire_n), .irq_pin_n_out(pin_out),
        .irq_pin_n_oe(pin_oe), .irq(irq));
    irq_wire_host u_host (.drv_oe(pin_oe), .drv_out(pin_out),
        .other_low(other_low), .wire_n(wire_n));
    // ------
    // Tasks
    // ------
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [2:0] sz, input logic [7:0] d,
                        output logic [7:0] r);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        hsize <= sz;
        htrans <= HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata[7:0];
    endtask
    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        logic [7:0] r;
        xfer(1'b1, {24'h0, i, 2'b00}, HSIZE_WORD, d, r);
    endtask
    task automatic rdc(input string nm, input logic [5:0] i,
                       input logic [7:0] m, input logic [7:0] e);
        logic [7:0] r;
        xfer(1'b0, {24'h0, i, 2'b00}, HSIZE_WORD, 8'h00, r);
        chk(nm, e, r & m);
    endtask
    task automatic pin(input string nm, input logic e);
        repeat (2) @(posedge hclk);
        @(negedge hclk);
        chk(nm, {7'h0, e}, {7'h0, pin_oe});
        @(posedge hclk);
    endtask
    task automatic until_oe(input logic v, output int c);
        c = 0;
        do begin
            @(negedge hclk);
            c++;
        end while (pin_oe !== v && c < 3 * SECN);
    endtask
    task automatic alarm_try(input logic [7:0] ext, input logic [7:0] wday,
                             input logic [7:0] date, input logic [7:0] ahr,
                             input logic [7:0] aday, input logic e);
        wr(IDX_EXT, ext);
        wr(IDX_WDAY, wday);
        wr(IDX_DATE, date);
        wr(IDX_HOUR, 8'h07);
        wr(IDX_MIN, 8'h00);
        wr(IDX_AL_MIN, 8'h80);
        wr(IDX_AL_HOUR, ahr);
        wr(IDX_AL_DAY, aday);
        wr(IDX_SEC, 8'h59);
        wr(IDX_FLAG, 8'h00);
        repeat (SECN + 4) @(posedge hclk);
        rdc("alarm flag", IDX_FLAG, 8'h08, e ? 8'h08 : 8'h00);
    endtask
    task automatic print_verdict();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge hclk);
        bad_count++;
        print_verdict();
    end
    // ------
    // Tests
    // ------
    initial begin
        logic [7:0] r;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc("ext reset", IDX_EXT, 8'hff, 8'h00);
        rdc("flags reset", IDX_FLAG, 8'hff, 8'h00);
        rdc("ctrl reset", IDX_CTRL, 8'hff, 8'h00);
        rdc("date reset", IDX_DATE, 8'hff, 8'h01);
        wr(IDX_EXT, 8'h28);
        xfer(1'b1, {24'h1, IDX_EXT, 2'b00}, HSIZE_WORD, 8'h00, r);
        rdc("ext rw", IDX_EXT, 8'hff, 8'h28);
        wr(6'h3f, 8'hff);
        rdc("unmapped", 6'h3f, 8'hff, 8'h00);
        xfer(1'b0, 32'h100, HSIZE_WORD, 8'h00, r);
        chk("high address", 8'h00, r);
        xfer(1'b0, 32'h0, HSIZE_WORD, 8'h00, r);
        chk("index zero", 8'h00, r);
        wr(IDX_CTRL, 8'h00);
        wr(IDX_EXT, 8'h00);
        wr(IDX_SEC, 8'h00);
        wr(IDX_FLAG, 8'h00);
        wr(IDX_CTRL, 8'h20);
        until_oe(1'b1, n);
        until_oe(1'b0, n1);
        until_oe(1'b1, n2);
        chk("update low", 8'h1, {7'h0, n1 >= RELN && n1 <= RELN + 2});
        chk("update period", SECN[7:0], 8'(n1 + n2));
        @(posedge hclk);
        rdc("flag held", IDX_FLAG, 8'hff, 8'h20);
        wr(IDX_FLAG, 8'h00);
        rdc("flag cleared", IDX_FLAG, 8'hff, 8'h00);
        wr(IDX_FLAG, 8'h20);
        rdc("flag one ignored", IDX_FLAG, 8'hff, 8'h00);
        wr(IDX_CTRL, 8'h00);
        repeat (2 * SECN) @(posedge hclk);
        pin("update disabled pin", 1'b0);
        rdc("update flag runs", IDX_FLAG, 8'hff, 8'h20);
        wr(IDX_CTRL, 8'h40);
        wr(IDX_FLAG, 8'h00);
        repeat (2 * SECN) @(posedge hclk);
        rdc("stopped flag", IDX_FLAG, 8'hff, 8'h00);
        wr(IDX_CTRL, 8'h00);
        wr(IDX_EXT, 8'h20);
        wr(IDX_SEC, 8'h58);
        wr(IDX_FLAG, 8'h00);
        repeat (SECN) @(posedge hclk);
        rdc("minute mode sec", IDX_FLAG, 8'h20, 8'h00);
        repeat (SECN) @(posedge hclk);
        rdc("minute mode min", IDX_FLAG, 8'h20, 8'h20);
        alarm_try(8'h00, 8'h00, 8'h01, 8'h07, 8'h3e, 1'b0);
        alarm_try(8'h00, 8'h00, 8'h01, 8'h07, 8'h80, 1'b1);
        alarm_try(8'h08, 8'h00, 8'h15, 8'h07, 8'h15, 1'b1);
        alarm_try(8'h08, 8'h00, 8'h14, 8'h07, 8'h15, 1'b0);
        alarm_try(8'h00, 8'h06, 8'h01, 8'h05, 8'h40, 1'b0);
        alarm_try(8'h00, 8'h06, 8'h01, 8'h80, 8'h40, 1'b1);
        alarm_try(8'h00, 8'h03, 8'h01, 8'h07, 8'h3e, 1'b1);
        wr(IDX_CTRL, 8'h08);
        pin("alarm pin", 1'b1);
        wr(IDX_CTRL, 8'h00);
        pin("alarm disabled", 1'b0);
        rdc("alarm pending", IDX_FLAG, 8'h08, 8'h08);
        wr(IDX_CTRL, 8'h08);
        pin("alarm reenabled", 1'b1);
        wr(IDX_FLAG, 8'h08);
        pin("alarm one ignored", 1'b1);
        wr(IDX_CTRL, 8'h28);
        repeat (2 * SECN) @(posedge hclk);
        wr(IDX_CTRL, 8'h08);
        pin("shared pin held", 1'b1);
        wr(IDX_FLAG, 8'h00);
        pin("alarm cleared", 1'b0);
        other_low <= 1'b1;
        repeat (4) @(posedge hclk);
        rdc("wire low seen", IDX_ISTAT, 8'h04, 8'h04);
        other_low <= 1'b0;
        wr(IDX_IMASK, 8'h00);
        wr(IDX_SEC, 8'h00);
        wr(IDX_ISTAT, 8'h03);
        repeat (SECN) @(posedge hclk);
        rdc("status update", IDX_ISTAT, 8'h03, 8'h02);
        @(negedge hclk);
        chk("irq masked", 8'h00, {7'h0, irq});
        @(posedge hclk);
        wr(IDX_IMASK, 8'h02);
        repeat (2) @(negedge hclk);
        chk("irq raised", 8'h01, {7'h0, irq});
        @(posedge hclk);
        wr(IDX_ISTAT, 8'h02);
        repeat (2) @(negedge hclk);
        chk("irq cleared", 8'h00, {7'h0, irq});
        print_verdict();
    end
endmodule
